/* File: design/bso_top.sv */
// Functional notes
// - Four outputs, each picks function by code
// - Code 22: low on lasting speed error
// - Code 23: overspeed low, 0.5% hysteresis
// - Overspeed output regardless; fault only unsuppressed
// - Code 24: low while any alarm
// - Status alarm bit inverse of code 24
// - Code 25: low on motor temperature alarms
// - Code 26: low on power thermal alarm
// - Code 27: low on cooling fault, even suppressed
// - Code 28: field current threshold with hysteresis
// - Code 29: high at either current limit
// - Code 30: high energizes positive field contactor
// - Code 31: high energizes negative field contactor
// - Contactors sequenced from reversal or braking requests
// - Code 32: torque direction I versus II
// - Code 33: high when junction rise above 5%
// - Codes 34, 35: two configurable limit monitors
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
module bso_top
	import bso_pkg::*;
#(
	parameter int unsigned MS_CNT = MS_CYCLES
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	// Avalon-MM slave
	input  wire logic [5:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// Monitored quantities
	input  wire bso_meas_t         meas_i,
	input  wire bso_alarm_t        alarm_i,
	input  wire bso_tq_dir_t       torque_dir_sel_i,
	input  wire logic              torque_ready_dir1_i,
	input  wire logic signed [15:0] limit_src1_i,
	input  wire logic signed [15:0] limit_src2_i,
	// Field reversal control
	input  wire logic              field_enable_i,
	input  wire logic              reverse_by_field_request_i,
	input  wire logic              brake_by_field_request_i,
	// Terminals and status
	output logic      [3:0]        select_out_o,
	output logic                   field_contactor_pos_out_o,
	output logic                   field_contactor_neg_out_o,
	output logic                   overspeed_fault_o,
	output logic                   cooling_fault_o,
	output logic                   status_word_alarm_bit_o,
	output logic                   irq_o
);

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic pick_func(input logic [5:0] code,
		input logic [FUNC_CNT-1:0] funcs);
		logic [5:0] idx;
		idx = code - CODE_FIRST;
		if (code < CODE_FIRST || code > CODE_LAST) begin
			return 1'b0;
		end
		return funcs[idx[3:0]];
	endfunction

	function automatic logic signed [16:0] sx(input logic signed [15:0] v);
		return {v[15], v};
	endfunction

	// Bus handshake: one wait cycle, then the answer
	logic              wait_ff;
	logic              nxt_wait;
	logic [31:0]       rdata_ff;
	logic [31:0]       nxt_rdata;
	logic              req;
	logic              wr_hit;

	assign req      = avs_read_i | avs_write_i;
	assign nxt_wait = ~(req & wait_ff);
	assign wr_hit   = avs_write_i & ~wait_ff;

	// Configuration words
	logic [31:0]       cfg_ff [CFG_WORDS];
	logic [5:0]        cfg_addr [CFG_WORDS];

	assign cfg_addr[0] = REG_SEL;
	assign cfg_addr[1] = REG_SPD_THR;
	assign cfg_addr[2] = REG_SPD_TIME;
	assign cfg_addr[3] = REG_OVS_THR;
	assign cfg_addr[4] = REG_FLD_CFG;
	assign cfg_addr[5] = REG_LIM1_CFG;
	assign cfg_addr[6] = REG_LIM2_CFG;
	assign cfg_addr[7] = REG_CTRL;
	assign cfg_addr[8] = REG_IRQ_MASK;

	for (genvar g = 0; g < CFG_WORDS; g++) begin : g_cfg
		wire logic we = wr_hit & (avs_address_i == cfg_addr[g]);
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cfg_ff[g] <= RST_WORD;
			end else if (we) begin
				cfg_ff[g] <= be_merge(cfg_ff[g], avs_writedata_i, avs_byteenable_i);
			end
		end
	end

	wire logic [31:0]  sel_word    = cfg_ff[0];
	wire logic [15:0]  spd_err_thr = cfg_ff[1][15:0];
	wire logic [15:0]  spd_err_time = cfg_ff[2][15:0];
	wire logic signed [15:0] ovs_thr = cfg_ff[3][15:0];
	wire logic signed [15:0] fld_thr = cfg_ff[4][15:0];
	wire logic [15:0]  fld_hyst    = cfg_ff[4][31:16];
	wire bso_lim_cfg_t lim_cfg [2];
	wire logic         ovs_supp    = cfg_ff[7][CTRL_OVS_SUPP];
	wire logic         cool_supp   = cfg_ff[7][CTRL_COOL_SUP];
	wire logic [IRQ_W-1:0] irq_mask = cfg_ff[8][IRQ_W-1:0];

	assign lim_cfg[0] = bso_lim_cfg_t'(cfg_ff[5]);
	assign lim_cfg[1] = bso_lim_cfg_t'(cfg_ff[6]);

	// Millisecond time base
	logic [15:0]       ms_cnt_ff;
	logic              ms_tick;

	assign ms_tick = (ms_cnt_ff == 16'(MS_CNT - 1));

	// Speed error timer
	logic signed [16:0] spd_diff;
	logic [16:0]        spd_abs;
	logic               spd_over;
	logic [15:0]        err_ms_ff;
	logic [15:0]        nxt_err_ms;
	logic               spd_ok;

	assign spd_diff = sx(meas_i.speed_setpoint) - sx(meas_i.speed_actual_value);
	assign spd_abs  = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);
	assign spd_over = spd_abs > {1'b0, spd_err_thr};
	// Saturating count keeps a long deviation from wrapping back to "reached"
	assign nxt_err_ms = !spd_over ? 16'h0000 :
		(ms_tick && err_ms_ff != 16'hFFFF) ? err_ms_ff + 16'h0001 : err_ms_ff;
	assign spd_ok = ~(spd_over && err_ms_ff > spd_err_time);

	// Overspeed with hysteresis
	logic               ovs_ff;
	logic               nxt_ovs;
	logic signed [16:0] ovs_upper;

	assign ovs_upper = $signed(17'(sx(ovs_thr)) + 17'({1'b0, OVS_HYST}));
	assign nxt_ovs = (sx(meas_i.speed_actual_value) > ovs_upper) ? 1'b1 :
		(sx(meas_i.speed_actual_value) < sx(ovs_thr)) ? 1'b0 : ovs_ff;

	// Field current with hysteresis
	logic               fld_ff;
	logic               nxt_fld;
	logic signed [16:0] fld_upper;

	assign fld_upper = $signed(17'(sx(fld_thr)) + 17'({1'b0, fld_hyst}));
	assign nxt_fld = (sx(meas_i.field_current_actual) > fld_upper) ? 1'b1 :
		(sx(meas_i.field_current_actual) < sx(fld_thr)) ? 1'b0 : fld_ff;

	// Free limit monitors
	logic [1:0]         lim_ff;
	logic [1:0]         nxt_lim;
	logic signed [15:0] lim_src [2];

	assign lim_src[0] = limit_src1_i;
	assign lim_src[1] = limit_src2_i;

	for (genvar m = 0; m < 2; m++) begin : g_lim
		wire logic signed [16:0] upper =
			$signed(17'(sx(lim_cfg[m].thr)) + 17'({2'b00, lim_cfg[m].hyst}));
		assign nxt_lim[m] = (sx(lim_src[m]) > upper) ? 1'b1 :
			(sx(lim_src[m]) < sx(lim_cfg[m].thr)) ? 1'b0 : lim_ff[m];
	end

	// Field contactor sequencing
	bso_fc_state_t      fc_ff;
	bso_fc_state_t      nxt_fc;
	logic               fc_to_neg_ff;
	logic               nxt_fc_to_neg;
	logic [15:0]        gap_ms_ff;
	logic               rev_req_d_ff;
	logic               brk_req_d_ff;
	logic               reversal;
	logic               gap_done;

	assign reversal = (reverse_by_field_request_i & ~rev_req_d_ff) |
		(brake_by_field_request_i & ~brk_req_d_ff);
	assign gap_done = (gap_ms_ff == 16'(FIELD_GAP_MS)) && ms_tick;

	// Break-before-make: both contactors open during the gap
	always_comb begin
		nxt_fc        = fc_ff;
		nxt_fc_to_neg = fc_to_neg_ff;
		if (!field_enable_i) begin
			nxt_fc = FC_OFF;
		end else begin
			unique case (fc_ff)
				FC_OFF: begin
					nxt_fc        = FC_POS;
					nxt_fc_to_neg = 1'b0;
				end
				FC_POS: begin
					if (reversal) begin
						nxt_fc        = FC_GAP;
						nxt_fc_to_neg = 1'b1;
					end
				end
				FC_NEG: begin
					if (reversal) begin
						nxt_fc        = FC_GAP;
						nxt_fc_to_neg = 1'b0;
					end
				end
				FC_GAP: begin
					if (gap_done) begin
						nxt_fc = fc_to_neg_ff ? FC_NEG : FC_POS;
					end
				end
			endcase
		end
	end

	// Function vector, index = code - 22
	logic [FUNC_CNT-1:0] funcs;
	logic                alarm_lvl;
	logic                tq_lvl;
	logic                lim_hit;

	assign alarm_lvl = ~alarm_i.any_alarm;
	assign lim_hit = (meas_i.current_setpoint >= meas_i.pos_current_limit) ||
		(meas_i.current_setpoint <= meas_i.neg_current_limit);
	assign tq_lvl = (torque_dir_sel_i == TQ_DIR1) ||
		(torque_dir_sel_i != TQ_DIR2 && torque_ready_dir1_i);

	assign funcs[0]  = spd_ok;
	assign funcs[1]  = ~ovs_ff;
	assign funcs[2]  = alarm_lvl;
	assign funcs[3]  = ~(alarm_i.motor_overtemp_alarm | alarm_i.motor_temp_binary_alarm |
		alarm_i.motor_temp_analog_alarm);
	assign funcs[4]  = ~alarm_i.power_section_thermal_alarm;
	assign funcs[5]  = ~alarm_i.cooling_cond;
	assign funcs[6]  = fld_ff;
	assign funcs[7]  = lim_hit;
	assign funcs[8]  = (fc_ff == FC_POS);
	assign funcs[9]  = (fc_ff == FC_NEG);
	assign funcs[10] = tq_lvl;
	assign funcs[11] = meas_i.junction_rise > WARM_LEVEL;
	assign funcs[12] = lim_ff[0] ^ lim_cfg[0].invert;
	assign funcs[13] = lim_ff[1] ^ lim_cfg[1].invert;

	logic [3:0]          nxt_sel_out;

	for (genvar o = 0; o < 4; o++) begin : g_out
		assign nxt_sel_out[o] =
			pick_func(sel_word[o*SEL_STRIDE +: SEL_CODE_W], funcs);
	end

	// Interrupt events
	logic [IRQ_W-1:0]    irq_stat_ff;
	logic [IRQ_W-1:0]    nxt_irq_stat;
	logic [IRQ_W-1:0]    irq_evt;
	logic [IRQ_W-1:0]    irq_clr;
	logic                cool_d_ff;
	logic                spd_ok_d_ff;

	assign irq_evt[IRQ_OVS]     = nxt_ovs & ~ovs_ff;
	assign irq_evt[IRQ_SPD_ERR] = ~spd_ok & spd_ok_d_ff;
	assign irq_evt[IRQ_COOL]    = alarm_i.cooling_cond & ~cool_d_ff;
	assign irq_evt[IRQ_FIELD]   = (fc_ff == FC_GAP) & gap_done;
	assign irq_clr = (wr_hit && avs_address_i == REG_IRQ_STAT) ?
		avs_writedata_i[IRQ_W-1:0] & {IRQ_W{avs_byteenable_i[0]}} : '0;
	// A new event in the clearing cycle survives the clear
	assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

	// Read mux
	logic [31:0]         status_word;
	logic                cfg_hit;
	logic [31:0]         cfg_rd;

	assign status_word = {20'h00000, fc_ff, cooling_fault_o, overspeed_fault_o,
		status_word_alarm_bit_o, lim_ff, fld_ff, select_out_o};

	always_comb begin
		cfg_hit = 1'b0;
		cfg_rd  = 32'h0000_0000;
		for (int i = 0; i < CFG_WORDS; i++) begin
			if (avs_address_i == cfg_addr[i]) begin
				cfg_hit = 1'b1;
				cfg_rd  = cfg_ff[i];
			end
		end
	end

	// Unmapped addresses read as zero
	assign nxt_rdata = (!(avs_read_i & wait_ff)) ? rdata_ff :
		cfg_hit ? cfg_rd :
		(avs_address_i == REG_STATUS) ? status_word :
		(avs_address_i == REG_IRQ_STAT) ? {28'h0000000, irq_stat_ff} :
		32'h0000_0000;

	// State registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_ff      <= 1'b1;
			rdata_ff     <= 32'h0000_0000;
			ms_cnt_ff    <= 16'h0000;
			err_ms_ff    <= 16'h0000;
			ovs_ff       <= 1'b0;
			fld_ff       <= 1'b0;
			lim_ff       <= 2'b00;
			fc_ff        <= FC_OFF;
			fc_to_neg_ff <= 1'b0;
			gap_ms_ff    <= 16'h0000;
			rev_req_d_ff <= 1'b0;
			brk_req_d_ff <= 1'b0;
			irq_stat_ff  <= '0;
			cool_d_ff    <= 1'b0;
			spd_ok_d_ff  <= 1'b1;
		end else begin
			wait_ff      <= nxt_wait;
			rdata_ff     <= nxt_rdata;
			ms_cnt_ff    <= ms_tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
			err_ms_ff    <= nxt_err_ms;
			ovs_ff       <= nxt_ovs;
			fld_ff       <= nxt_fld;
			lim_ff       <= nxt_lim;
			fc_ff        <= nxt_fc;
			fc_to_neg_ff <= nxt_fc_to_neg;
			gap_ms_ff    <= (nxt_fc != FC_GAP || fc_ff != FC_GAP) ? 16'h0000 :
				ms_tick ? gap_ms_ff + 16'h0001 : gap_ms_ff;
			rev_req_d_ff <= reverse_by_field_request_i;
			brk_req_d_ff <= brake_by_field_request_i;
			irq_stat_ff  <= nxt_irq_stat;
			cool_d_ff    <= alarm_i.cooling_cond;
			spd_ok_d_ff  <= spd_ok;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			select_out_o              <= 4'h0;
			field_contactor_pos_out_o <= 1'b0;
			field_contactor_neg_out_o <= 1'b0;
			overspeed_fault_o         <= 1'b0;
			cooling_fault_o           <= 1'b0;
			status_word_alarm_bit_o   <= 1'b0;
			irq_o                     <= 1'b0;
		end else begin
			select_out_o              <= nxt_sel_out;
			field_contactor_pos_out_o <= (nxt_fc == FC_POS);
			field_contactor_neg_out_o <= (nxt_fc == FC_NEG);
			overspeed_fault_o         <= nxt_ovs & ~ovs_supp;
			cooling_fault_o           <= alarm_i.cooling_cond & ~cool_supp;
			status_word_alarm_bit_o   <= ~alarm_lvl;
			irq_o                     <= |(nxt_irq_stat & irq_mask);
		end
	end

	assign avs_readdata_o    = rdata_ff;
	assign avs_waitrequest_o = wait_ff;

endmodule

/* File: pkg/bso_pkg.sv */
package bso_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MS_TIME_NS    = 1000000;
	localparam int unsigned MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned FIELD_GAP_MS  = 100;

	// Register byte offsets
	localparam logic [5:0] REG_SEL      = 6'h00;
	localparam logic [5:0] REG_SPD_THR  = 6'h04;
	localparam logic [5:0] REG_SPD_TIME = 6'h08;
	localparam logic [5:0] REG_OVS_THR  = 6'h0C;
	localparam logic [5:0] REG_FLD_CFG  = 6'h10;
	localparam logic [5:0] REG_LIM1_CFG = 6'h14;
	localparam logic [5:0] REG_LIM2_CFG = 6'h18;
	localparam logic [5:0] REG_CTRL     = 6'h1C;
	localparam logic [5:0] REG_IRQ_MASK = 6'h20;
	localparam logic [5:0] REG_STATUS   = 6'h24;
	localparam logic [5:0] REG_IRQ_STAT = 6'h28;
	localparam int unsigned CFG_WORDS   = 9;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Field positions
	localparam int unsigned SEL_CODE_W    = 6;
	localparam int unsigned SEL_STRIDE    = 8;
	localparam int unsigned CTRL_OVS_SUPP = 0;
	localparam int unsigned CTRL_COOL_SUP = 1;
	localparam int unsigned IRQ_OVS       = 0;
	localparam int unsigned IRQ_SPD_ERR   = 1;
	localparam int unsigned IRQ_COOL      = 2;
	localparam int unsigned IRQ_FIELD     = 3;
	localparam int unsigned IRQ_W         = 4;

	// Selection codes
	localparam logic [5:0] CODE_FIRST     = 6'h16;
	localparam logic [5:0] CODE_LAST      = 6'h23;
	localparam int unsigned FUNC_CNT      = 14;

	// Scaled values: 1 LSB = 0.01 percent
	localparam logic [15:0] OVS_HYST      = 16'h0032;
	localparam logic [15:0] WARM_LEVEL    = 16'h01F4;

	typedef enum logic [1:0] {
		FC_OFF = 2'b00,
		FC_POS = 2'b01,
		FC_GAP = 2'b10,
		FC_NEG = 2'b11
	} bso_fc_state_t;

	typedef enum logic [1:0] {
		TQ_NONE = 2'b00,
		TQ_DIR1 = 2'b01,
		TQ_DIR2 = 2'b10
	} bso_tq_dir_t;

	typedef struct packed {
		logic        invert;
		logic [14:0] hyst;
		logic [15:0] thr;
	} bso_lim_cfg_t;

	typedef struct packed {
		logic signed [15:0] speed_setpoint;
		logic signed [15:0] speed_actual_value;
		logic signed [15:0] field_current_actual;
		logic signed [15:0] current_setpoint;
		logic signed [15:0] pos_current_limit;
		logic signed [15:0] neg_current_limit;
		logic        [15:0] junction_rise;
	} bso_meas_t;

	typedef struct packed {
		logic any_alarm;
		logic motor_overtemp_alarm;
		logic motor_temp_binary_alarm;
		logic motor_temp_analog_alarm;
		logic power_section_thermal_alarm;
		logic cooling_cond;
	} bso_alarm_t;

endpackage

/* File: testbench/bso_monitor.sv */
module bso_monitor
	import bso_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Bus handshake
	input  wire logic       avs_read_i,
	input  wire logic       avs_write_i,
	input  wire logic       avs_waitrequest_o,
	// Monitored inputs
	input  wire bso_alarm_t alarm_i,
	input  wire logic       reverse_by_field_request_i,
	// Terminals and status
	input  wire logic [3:0] select_out_o,
	input  wire logic       field_contactor_pos_out_o,
	input  wire logic       field_contactor_neg_out_o,
	input  wire logic       cooling_fault_o,
	input  wire logic       status_word_alarm_bit_o,
	input  wire logic       irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_reset_outs_low: assert property ($rose(rst_n_i) |->
		select_out_o == 4'h0 && !field_contactor_pos_out_o && !irq_o)
		else $error("outputs active right after reset");
	a_alarm_bit_inv: assert property ($past(rst_n_i) |->
		status_word_alarm_bit_o == $past(alarm_i.any_alarm))
		else $error("alarm status bit does not follow alarm");
	a_cool_fault_src: assert property ($past(rst_n_i) && cooling_fault_o |->
		$past(alarm_i.cooling_cond))
		else $error("cooling fault without cause");
	a_field_excl: assert property (
		!(field_contactor_pos_out_o && field_contactor_neg_out_o))
		else $error("both field contactors energized");
	// Short check only; the full dead time is measured by the bench
	a_field_gap: assert property ($fell(field_contactor_pos_out_o) |->
		!field_contactor_neg_out_o [*8])
		else $error("negative contactor closed without gap");
	a_field_drop: assert property (
		$rose(reverse_by_field_request_i) && field_contactor_pos_out_o |->
		##[1:3] !field_contactor_pos_out_o)
		else $error("positive contactor kept after reversal");
	a_wait_answer: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered");
	a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");

	c_neg_closed: cover property ($rose(field_contactor_neg_out_o));
	c_irq_raised: cover property ($rose(irq_o));
	c_alarm_seen: cover property ($fell(select_out_o[0]));
endmodule

/* File: testbench/bso_relays.sv */
module bso_relays
	import bso_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Coil drive from the terminals
	input  wire logic [5:0] coil_i,
	// Contact state seen by the plant
	output logic      [5:0] contact_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] stage_ff;

	// Two-cycle pickup, no bounce: keeps checks deterministic
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage_ff  <= 6'h00;
			contact_o <= 6'h00;
		end else begin
			stage_ff  <= coil_i;
			contact_o <= stage_ff;
		end
	end
endmodule

/* File: testbench/bso_top_tb.sv */
module bso_top_tb
	import bso_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS_SIM = 4;
	logic               clk, rst_n, rd, wr, wreq, fen, rev, brk, trdy;
	logic               fp, fn, ovf, clf, sab, irq;
	logic [5:0]         adr, rly;
	logic [31:0]        wd, rdat;
	logic [3:0]         so;
	logic signed [15:0] ls1, ls2;
	bso_meas_t          m;
	bso_alarm_t         al;
	bso_tq_dir_t        tq;
	int                 mismatches, comparisons;

	bso_top #(.MS_CNT(MS_SIM)) uut (
		.clk_i(clk), .rst_n_i(rst_n),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.meas_i(m), .alarm_i(al), .torque_dir_sel_i(tq),
		.torque_ready_dir1_i(trdy), .limit_src1_i(ls1), .limit_src2_i(ls2),
		.field_enable_i(fen), .reverse_by_field_request_i(rev),
		.brake_by_field_request_i(brk), .select_out_o(so),
		.field_contactor_pos_out_o(fp), .field_contactor_neg_out_o(fn),
		.overspeed_fault_o(ovf), .cooling_fault_o(clf),
		.status_word_alarm_bit_o(sab), .irq_o(irq)
	);
	bso_relays plant (.clk_i(clk), .rst_n_i(rst_n), .coil_i({fn, fp, so}), .contact_o(rly));

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	task automatic cmpb(input logic g, input logic e, input string s);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %s got %b want %b", $time, s, g, e);
		end
	endtask
	task automatic cmpw(input logic [31:0] g, input logic [31:0] e, input string s);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Request held until waitrequest is sampled low; the watchdog ends a hang
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		adr <= a;
		wd  <= d;
		wr  <= w;
		rd  <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic ckr(input logic [5:0] a, input logic [31:0] e, input string s);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		cmpw(q, e, s);
	endtask
	// Field changeover by reversal or braking request, then gap measurement
	task automatic flip(input logic brake);
		int n;
		@(posedge clk);
		if (brake) brk <= 1'b1;
		else rev <= 1'b1;
		wt(3);
		cmpb(fp | fn, 1'b0, "both released");
		@(posedge clk);
		rev <= 1'b0;
		brk <= 1'b0;
		n = 4;
		while ((brake ? fp : fn) !== 1'b1 && n < 900) begin
			@(posedge clk);
			n++;
		end
		wt(3);
		cmpb(n >= FIELD_GAP_MS * MS_SIM, 1'b1, "dead time");
		cmpb(brake ? fp : fn, 1'b1, "other contactor");
		cmpb(so[brake ? 0 : 1], 1'b1, "terminal");
		cmpb(rly[brake ? 4 : 5], 1'b1, "relay picked");
		cmpb(irq, 1'b1, "changeover irq");
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end

	initial begin
		{clk, rst_n, rd, wr, fen, rev, brk, trdy} = 8'h00;
		{adr, wd, ls1, ls2, m, al} = '0;
		tq = TQ_NONE;
		mismatches = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		ckr(REG_SEL, RST_WORD, "sel reset");
		ckr(REG_IRQ_MASK, RST_WORD, "mask reset");
		wrr(6'h2C, 32'hFFFF_FFFF);
		ckr(6'h2C, RST_WORD, "unmapped");
		cmpb(so === 4'h0, 1'b1, "outputs idle");
		$display("test registers done");
		wrr(REG_SEL, 32'h1B1A_1918);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			al <= bso_alarm_t'(6'h20 >> i);
			wt(3);
			cmpb(so[0], !al.any_alarm, "any alarm");
			cmpb(so[1], !(al.motor_overtemp_alarm | al.motor_temp_binary_alarm
				| al.motor_temp_analog_alarm), "motor alarm");
			cmpb(so[2], !al.power_section_thermal_alarm, "power alarm");
			cmpb(so[3], !al.cooling_cond, "cooling");
			cmpb(sab, al.any_alarm, "alarm bit");
			cmpb(clf, al.cooling_cond, "cooling fault");
		end
		wrr(REG_CTRL, 32'h0000_0002);
		@(posedge clk);
		al <= bso_alarm_t'(6'h01);
		wt(3);
		cmpb(so[3], 1'b0, "cooling suppressed out");
		cmpb(clf, 1'b0, "cooling fault suppressed");
		@(posedge clk);
		al <= '0;
		ckr(REG_IRQ_STAT, 32'h0000_0004, "cooling event");
		cmpb(irq, 1'b0, "irq masked");
		wrr(REG_IRQ_MASK, 32'h0000_0004);
		wt(2);
		cmpb(irq, 1'b1, "irq raised");
		wrr(REG_IRQ_STAT, 32'h0000_0004);
		wt(2);
		cmpb(irq, 1'b0, "irq cleared");
		wrr(REG_CTRL, 32'h0000_0001);
		$display("test alarms done");
		wrr(REG_SEL, 32'h1721_201D);
		wrr(REG_OVS_THR, 32'h0000_03E8);
		@(posedge clk);
		m.pos_current_limit  <= 16'h0320;
		m.neg_current_limit  <= 16'hFCE0;
		m.current_setpoint   <= 16'h031F;
		m.junction_rise      <= 16'h01F4;
		m.speed_actual_value <= 16'h041A;
		wt(3);
		cmpb(so[0], 1'b0, "below limit");
		cmpb(so[2], 1'b0, "warm at level");
		cmpb(so[3], 1'b1, "speed at hysteresis");
		@(posedge clk);
		m.current_setpoint   <= 16'hFCE0;
		m.junction_rise      <= 16'h01F5;
		m.speed_actual_value <= 16'h041B;
		wt(3);
		cmpb(so[0], 1'b1, "negative limit");
		cmpb(so[2], 1'b1, "warm");
		cmpb(so[3], 1'b0, "overspeed");
		cmpb(ovf, 1'b0, "fault suppressed");
		wrr(REG_CTRL, RST_WORD);
		@(posedge clk);
		m.current_setpoint   <= 16'h0320;
		m.speed_actual_value <= 16'h03FC;
		wt(3);
		cmpb(so[0], 1'b1, "positive limit");
		cmpb(so[3], 1'b0, "overspeed held");
		cmpb(ovf, 1'b1, "overspeed fault");
		@(posedge clk);
		m.speed_actual_value <= 16'h03E7;
		wt(3);
		cmpb(so[3], 1'b1, "overspeed gone");
		for (int j = 0; j < 6; j++) begin
			@(posedge clk);
			tq   <= bso_tq_dir_t'(j >> 1);
			trdy <= j[0];
			wt(3);
			cmpb(so[1], tq == TQ_DIR1 || (tq != TQ_DIR2 && trdy), "torque");
		end
		$display("test monitors done");
		wrr(REG_SEL, 32'h2322_161C);
		wrr(REG_FLD_CFG, 32'h0064_03E8);
		wrr(REG_LIM1_CFG, 32'h0010_0100);
		wrr(REG_LIM2_CFG, 32'h8010_0100);
		wrr(REG_SPD_THR, 32'h0000_0064);
		wrr(REG_SPD_TIME, 32'h0000_0002);
		@(posedge clk);
		m.speed_actual_value   <= 16'h0000;
		m.field_current_actual <= 16'h044C;
		ls1 <= 16'h0111;
		ls2 <= 16'h0111;
		wt(3);
		cmpb(so[0], 1'b0, "field at hysteresis");
		cmpb(so[1], 1'b1, "speed settled");
		cmpb(so[2], 1'b1, "limit one");
		cmpb(so[3], 1'b0, "limit two inverted");
		wrr(REG_IRQ_STAT, 32'h0000_000F);
		@(posedge clk);
		m.field_current_actual <= 16'h044D;
		m.speed_setpoint       <= 16'h01F4;
		ls1 <= 16'h00FF;
		ls2 <= 16'h00FF;
		wt(3);
		cmpb(so[0], 1'b1, "field above");
		cmpb(so[2], 1'b0, "limit one low");
		cmpb(so[3], 1'b1, "limit two high");
		wt(6);
		cmpb(so[1], 1'b1, "error too short");
		wt(9);
		cmpb(so[1], 1'b0, "error lasting");
		@(posedge clk);
		m.speed_setpoint       <= 16'h0000;
		m.field_current_actual <= 16'h03E8;
		wt(3);
		cmpb(so[1], 1'b1, "error gone");
		cmpb(so[0], 1'b1, "field at threshold");
		ckr(REG_IRQ_STAT, 32'h0000_0002, "speed event");
		@(posedge clk);
		m.field_current_actual <= 16'h03E7;
		wt(3);
		cmpb(so[0], 1'b0, "field low");
		$display("test thresholds done");
		wrr(REG_SEL, 32'h0000_1F1E);
		wrr(REG_IRQ_MASK, 32'h0000_0008);
		@(posedge clk);
		fen <= 1'b1;
		wt(4);
		cmpb(fp & so[0] & !fn, 1'b1, "positive field");
		flip(1'b0);
		wrr(REG_IRQ_STAT, 32'h0000_0008);
		wt(2);
		cmpb(irq, 1'b0, "field irq cleared");
		ckr(REG_STATUS, 32'h0000_0C02, "status word");
		flip(1'b1);
		$display("test contactors done");
		print_verdict();
	end
endmodule

bind bso_top bso_monitor u_mon (
	.clk_i                      (clk_i),
	.rst_n_i                    (rst_n_i),
	.avs_read_i                 (avs_read_i),
	.avs_write_i                (avs_write_i),
	.avs_waitrequest_o          (avs_waitrequest_o),
	.alarm_i                    (alarm_i),
	.reverse_by_field_request_i (reverse_by_field_request_i),
	.select_out_o               (select_out_o),
	.field_contactor_pos_out_o  (field_contactor_pos_out_o),
	.field_contactor_neg_out_o  (field_contactor_neg_out_o),
	.cooling_fault_o            (cooling_fault_o),
	.status_word_alarm_bit_o    (status_word_alarm_bit_o),
	.irq_o                      (irq_o)
);
